// [trig_delay.sv]
`timescale 1ns/10ps
`default_nettype none
`include "trig_mask_regs.svh"
module trig_delay (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        start_in,
  input  wire logic        tick_in,
  input  wire logic [16:0] count_in,
  output logic             done_out
);
  logic [16:0] cnt_reg;
  logic        busy_reg;

  //------------------------------------------------------------
  // Delay counter
  //------------------------------------------------------------
  // Counts capture ticks down, done pulse on reaching zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cnt_reg  <= 17'h0_0000;
      busy_reg <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        cnt_reg  <= count_in;
        busy_reg <= 1'b1;
      end else if (busy_reg && cnt_reg == 17'h0_0000) begin
        busy_reg <= 1'b0;
        done_out <= 1'b1;
      end else if (busy_reg && tick_in) begin
        cnt_reg  <= cnt_reg - 17'h0_0001;
      end
    end
  end
endmodule // trig_delay
`default_nettype wire

// [trig_mask_pkg.sv]
package trig_mask_pkg;
  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [17:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // Software commands and settings from the driver
  typedef struct packed {
    logic        arm;
    logic        stop;
    logic        force_trig;
    logic        trig_en;
    logic        trigger_out_direction;
    logic        clk_out_en;
    logic [15:0] delay;
    logic [15:0] os_factor;
  } ctrl_t;

  // Evaluated source conditions
  typedef struct packed {
    logic [1:0] ext_cond;
    logic [1:0] extra_cond;
    logic       and_hit;
  } src_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAIT  = 3'b010,
    ST_DELAY = 3'b100
  } state_t;
endpackage

// [trig_mask_regs.svh]
`ifndef TRIG_MASK_REGS_SVH
`define TRIG_MASK_REGS_SVH
//------------------------------------------------------------
// Overview of operation
//------------------------------------------------------------

//------------------------------------------------------------
// Register offsets
//------------------------------------------------------------
`define OFS_OR_AVAIL    18'h09DD0
`define OFS_OR_SEL      18'h09DDA
`define OFS_CH_AVAIL_LO 18'h09E02
`define OFS_CH_AVAIL_HI 18'h09E03
`define OFS_CH_SEL_LO   18'h09E0C
`define OFS_CH_SEL_HI   18'h09E0D
`define OFS_OS_FACTOR   18'h30DBB

//------------------------------------------------------------
// General mask bit positions
//------------------------------------------------------------
`define BIT_SOFT        0
`define BIT_EXT0        1
`define BIT_EXT1        2
`define BIT_EXTRA_TRIGGER_INPUT_A        8
`define BIT_EXTRA_TRIGGER_INPUT_B        9

//------------------------------------------------------------
// Reset values and board build
//------------------------------------------------------------
`define OR_SEL_RST      32'h0000_0001
`define ZERO32          32'h0000_0000
`define OS_ONE          16'h0001
`define OS_ZERO         16'h0000
`define BOARD_ACQ       1'b1
`define EXT1_FITTED     1'b0
`define CH_AVAIL_LO     32'h0000_00FF
`define CH_AVAIL_HI     32'h0000_0000
`define PIPE_LAT        17'h0_0007
`define EXT_SRC_MASK    32'h0000_0306
`endif

// [trigger_or_mask_engine.sv]
`timescale 1ns/10ps
`default_nettype none
`include "trig_mask_regs.svh"
module trigger_or_mask_engine (
  input  wire logic                     clk_in,
  input  wire logic                     sys_rst_in,
  input  wire trig_mask_pkg::reg_req_t  reg_req_in,
  input  wire trig_mask_pkg::ctrl_t     ctrl_in,
  input  wire trig_mask_pkg::src_t      src_in,
  input  wire logic [63:0]              chan_cond_in,
  input  wire logic                     extra_fitted_in,
  output logic [31:0]                   reg_rdata_out,
  output logic                          reg_ack_out,
  output logic                          trig_out,
  output logic                          trig_pin_out,
  output logic                          trig_pin_oe_out,
  output logic                          capture_en_out,
  output logic                          conv_clk_out,
  output logic [47:0]                   timestamp_out,
  output logic                          waiting_out
);
  trig_mask_pkg::state_t state_reg;
  trig_mask_pkg::state_t state_next;
  logic [31:0] or_sel_reg;
  logic [31:0] ch_sel_reg [2];
  logic [31:0] ch_avail [2];
  logic [31:0] or_avail;
  logic [31:0] gen_cond;
  logic [1:0]  ch_hit;
  logic [15:0] os_factor_reg;
  logic [15:0] div_cnt_reg;
  logic        tick_reg;
  logic        extra_fit_reg;
  logic [47:0] ts_reg;
  logic        or_hit;
  logic        ext_hit;
  logic        take;
  logic        cause_int_reg;
  logic        delay_done;
  logic [16:0] delay_total;

  //------------------------------------------------------------
  // Address decode
  //------------------------------------------------------------
  function automatic logic hit_at(input logic [17:0] a,
                                  input logic [17:0] ofs);
    hit_at = (a == ofs);
  endfunction

  //------------------------------------------------------------
  // Availability masks
  //------------------------------------------------------------
  // Fitted option captured by a clocked stage
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      extra_fit_reg <= 1'b0;
    end else begin
      extra_fit_reg <= extra_fitted_in;
    end
  end

  // Only existing sources show a set bit
  always_comb begin
    or_avail = `ZERO32;
    or_avail[`BIT_SOFT] = 1'b1;
    or_avail[`BIT_EXT0] = 1'b1;
    or_avail[`BIT_EXT1] = `EXT1_FITTED;
    or_avail[`BIT_EXTRA_TRIGGER_INPUT_A] = extra_fit_reg;
    or_avail[`BIT_EXTRA_TRIGGER_INPUT_B] = extra_fit_reg;
  end

  // Generator boards offer no channel sources
  assign ch_avail[0] = `BOARD_ACQ ? `CH_AVAIL_LO : `ZERO32;
  assign ch_avail[1] = `BOARD_ACQ ? `CH_AVAIL_HI : `ZERO32;

  //------------------------------------------------------------
  // Register writes
  //------------------------------------------------------------
  // General OR mask, software trigger selected after reset
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      or_sel_reg <= `OR_SEL_RST;
    end else if (reg_req_in.wr && hit_at(reg_req_in.addr, `OFS_OR_SEL)) begin
      or_sel_reg <= reg_req_in.wdata;
    end
  end

  // Channel OR mask words
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      ch_sel_reg[0] <= `ZERO32;
      ch_sel_reg[1] <= `ZERO32;
    end else if (reg_req_in.wr) begin
      if (hit_at(reg_req_in.addr, `OFS_CH_SEL_LO)) begin
        ch_sel_reg[0] <= reg_req_in.wdata;
      end
      if (hit_at(reg_req_in.addr, `OFS_CH_SEL_HI)) begin
        ch_sel_reg[1] <= reg_req_in.wdata;
      end
    end
  end

  //------------------------------------------------------------
  // Register reads
  //------------------------------------------------------------
  // One-cycle answer, unmapped offsets read zero
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      reg_ack_out   <= 1'b0;
      reg_rdata_out <= `ZERO32;
    end else begin
      reg_ack_out   <= reg_req_in.rd | reg_req_in.wr;
      reg_rdata_out <= `ZERO32;
      if (reg_req_in.rd) begin
        if (hit_at(reg_req_in.addr, `OFS_OR_AVAIL)) begin
          reg_rdata_out <= or_avail;
        end
        if (hit_at(reg_req_in.addr, `OFS_OR_SEL)) begin
          reg_rdata_out <= or_sel_reg;
        end
        if (hit_at(reg_req_in.addr, `OFS_CH_AVAIL_LO)) begin
          reg_rdata_out <= ch_avail[0];
        end
        if (hit_at(reg_req_in.addr, `OFS_CH_AVAIL_HI)) begin
          reg_rdata_out <= ch_avail[1];
        end
        if (hit_at(reg_req_in.addr, `OFS_CH_SEL_LO)) begin
          reg_rdata_out <= ch_sel_reg[0];
        end
        if (hit_at(reg_req_in.addr, `OFS_CH_SEL_HI)) begin
          reg_rdata_out <= ch_sel_reg[1];
        end
        if (hit_at(reg_req_in.addr, `OFS_OS_FACTOR)) begin
          reg_rdata_out <= {16'h0000, os_factor_reg};
        end
      end
    end
  end

  //------------------------------------------------------------
  // Oversampling and capture rate
  //------------------------------------------------------------
  // Factor from the driver, zero treated as one
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      os_factor_reg <= `OS_ONE;
    end else if (ctrl_in.os_factor == `OS_ZERO) begin
      os_factor_reg <= `OS_ONE;
    end else begin
      os_factor_reg <= ctrl_in.os_factor;
    end
  end

  // Capture path ticks once per factor converter clocks
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      div_cnt_reg <= `OS_ZERO;
      tick_reg    <= 1'b0;
    end else if (div_cnt_reg >= os_factor_reg - `OS_ONE) begin
      div_cnt_reg <= `OS_ZERO;
      tick_reg    <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + `OS_ONE;
      tick_reg    <= 1'b0;
    end
  end

  assign capture_en_out = tick_reg;

  // Converter clock marker on the clock output
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      conv_clk_out <= 1'b0;
    end else if (ctrl_in.clk_out_en) begin
      conv_clk_out <= ~conv_clk_out;
    end else begin
      conv_clk_out <= 1'b0;
    end
  end

  // Timestamp on every converter clock, cleared at start
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || ctrl_in.arm) begin
      ts_reg <= 48'h0000_0000_0000;
    end else begin
      ts_reg <= ts_reg + 48'h0000_0000_0001;
    end
  end

  //------------------------------------------------------------
  // OR mask stage
  //------------------------------------------------------------
  // General sources as mask-shaped condition word
  always_comb begin
    gen_cond = `ZERO32;
    gen_cond[`BIT_SOFT] = 1'b1;
    gen_cond[`BIT_EXT0] = src_in.ext_cond[0];
    gen_cond[`BIT_EXT1] = src_in.ext_cond[1];
    gen_cond[`BIT_EXTRA_TRIGGER_INPUT_A] = src_in.extra_cond[0];
    gen_cond[`BIT_EXTRA_TRIGGER_INPUT_B] = src_in.extra_cond[1];
  end

  // Channel words masked by select and availability
  genvar w;
  generate
    for (w = 0; w < 2; w++) begin : g_ch
      assign ch_hit[w] = |(chan_cond_in[w*32 +: 32] & ch_sel_reg[w] & ch_avail[w]);
    end
  endgenerate

  assign or_hit  = |(gen_cond & or_sel_reg & or_avail) | (|ch_hit);
  assign ext_hit = |(gen_cond & or_sel_reg & or_avail & `EXT_SRC_MASK);
  assign take    = ctrl_in.force_trig
                 | (ctrl_in.trig_en & (or_hit | src_in.and_hit));

  //------------------------------------------------------------
  // Trigger sequencer
  //------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      trig_mask_pkg::ST_IDLE: begin
        if (ctrl_in.arm) begin
          state_next = trig_mask_pkg::ST_WAIT;
        end
      end
      trig_mask_pkg::ST_WAIT: begin
        if (take) begin
          state_next = trig_mask_pkg::ST_DELAY;
        end
      end
      trig_mask_pkg::ST_DELAY: begin
        if (delay_done) begin
          state_next = trig_mask_pkg::ST_WAIT;
        end
      end
      default: begin
        state_next = trig_mask_pkg::ST_IDLE;
      end
    endcase
    if (ctrl_in.stop) begin
      state_next = trig_mask_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_reg <= trig_mask_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Cause kind kept; an external event is echoed when force or the software source bit is also set
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cause_int_reg <= 1'b0;
    end else if (state_reg == trig_mask_pkg::ST_WAIT && take) begin
      cause_int_reg <= ctrl_in.force_trig | ~ext_hit
                     | or_sel_reg[`BIT_SOFT];
    end
  end

  // Compensation only while sampling synchronously
  assign delay_total = {1'b0, ctrl_in.delay}
                     + ((os_factor_reg == `OS_ONE) ? `PIPE_LAT : 17'h0_0000);

  trig_delay u_delay (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .start_in   (state_reg == trig_mask_pkg::ST_WAIT && take && !ctrl_in.stop),
    .tick_in    (tick_reg),
    .count_in   (delay_total),
    .done_out   (delay_done)
  );

  //------------------------------------------------------------
  // Trigger outputs
  //------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      trig_out        <= 1'b0;
      trig_pin_out    <= 1'b0;
      trig_pin_oe_out <= 1'b0;
      waiting_out     <= 1'b0;
      timestamp_out   <= 48'h0000_0000_0000;
    end else begin
      trig_out        <= delay_done & (state_reg == trig_mask_pkg::ST_DELAY);
      trig_pin_out    <= delay_done & cause_int_reg & (state_reg == trig_mask_pkg::ST_DELAY)
                       & ctrl_in.trigger_out_direction;
      trig_pin_oe_out <= ctrl_in.trigger_out_direction;
      waiting_out     <= (state_next == trig_mask_pkg::ST_WAIT);
      if (delay_done && state_reg == trig_mask_pkg::ST_DELAY) begin
        timestamp_out <= ts_reg;
      end
    end
  end

  //------------------------------------------------------------
  // Checks
  //------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_or_reset;
    $past(sys_rst_in) |-> or_sel_reg == `OR_SEL_RST;
  endproperty
  a_or_reset: assert property (p_or_reset)
    else $error("or mask not software after reset");

  property p_os_nonzero;
    (ctrl_in.os_factor == `OS_ZERO) |=> os_factor_reg == `OS_ONE;
  endproperty
  a_os_nonzero: assert property (p_os_nonzero)
    else $error("oversampling factor not one");

  property p_force;
    (state_reg == trig_mask_pkg::ST_WAIT && ctrl_in.force_trig && !ctrl_in.stop)
      |=> state_reg == trig_mask_pkg::ST_DELAY;
  endproperty
  a_force: assert property (p_force)
    else $error("force did not start a trigger");

  property p_gate;
    (state_reg == trig_mask_pkg::ST_WAIT && !ctrl_in.trig_en && !ctrl_in.force_trig)
      |=> state_reg != trig_mask_pkg::ST_DELAY;
  endproperty
  a_gate: assert property (p_gate)
    else $error("trigger passed while disabled");

  property p_one_shot;
    trig_out |=> !trig_out;
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("trigger longer than one cycle");

  property p_pin_off;
    !trig_pin_oe_out |-> !trig_pin_out;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("pin driven while output off");

  property p_or_hit;
    (state_reg == trig_mask_pkg::ST_WAIT && ctrl_in.trig_en && or_hit && !ctrl_in.stop)
      |=> state_reg == trig_mask_pkg::ST_DELAY;
  endproperty
  a_or_hit: assert property (p_or_hit)
    else $error("enabled source ignored");

  property p_ts;
    (!$past(sys_rst_in) && !$past(ctrl_in.arm))
      |-> ts_reg == $past(ts_reg) + 48'h0000_0000_0001;
  endproperty
  a_ts: assert property (p_ts)
    else $error("timestamp missed a clock");

  property p_tick;
    (tick_reg && os_factor_reg > `OS_ONE && $stable(os_factor_reg)) |=> !tick_reg;
  endproperty
  a_tick: assert property (p_tick)
    else $error("capture tick too fast");
endmodule // trigger_or_mask_engine
`default_nettype wire

// [trigger_or_mask_engine_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "trig_mask_regs.svh"
module trigger_or_mask_engine_test;
  logic                    clk_in = 1'b0;
  logic                    sys_rst_in;
  trig_mask_pkg::reg_req_t reg_req;
  trig_mask_pkg::ctrl_t    ctrl;
  trig_mask_pkg::src_t     src;
  logic [63:0]             chan_cond;
  logic                    extra_fitted;
  logic [31:0]             reg_rdata_out;
  logic                    reg_ack_out;
  logic                    trig_out;
  logic                    trig_pin_out;
  logic                    trig_pin_oe_out;
  logic                    capture_en_out;
  logic                    conv_clk_out;
  logic [47:0]             timestamp_out;
  logic                    waiting_out;
  int                      n_mismatch = 0;
  int                      checked = 0;
  int                      n_trig, n_pin, first_trig, n_cap, n_clk, tc_a, tc_b, lat0;
  logic [47:0]             ts_a, ts_b;

  // Free-running 10 MHz clock
  always #50 clk_in = ~clk_in;

  trigger_or_mask_engine trigger_or_mask_engine_inst (
    .clk_in          (clk_in),
    .sys_rst_in      (sys_rst_in),
    .reg_req_in      (reg_req),
    .ctrl_in         (ctrl),
    .src_in          (src),
    .chan_cond_in    (chan_cond),
    .extra_fitted_in (extra_fitted),
    .reg_rdata_out   (reg_rdata_out),
    .reg_ack_out     (reg_ack_out),
    .trig_out        (trig_out),
    .trig_pin_out    (trig_pin_out),
    .trig_pin_oe_out (trig_pin_oe_out),
    .capture_en_out  (capture_en_out),
    .conv_clk_out    (conv_clk_out),
    .timestamp_out   (timestamp_out),
    .waiting_out     (waiting_out)
  );

  //------------------------------------------------------------
  // Helper tasks
  //------------------------------------------------------------
  task automatic report_and_stop();
    $display("Counts: %0d checks, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // One comparison, reported at once on mismatch
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  // Register write: strobe one cycle, taken at the next rising edge
  task automatic reg_write(input logic [17:0] a, input logic [31:0] d);
    @(negedge clk_in);
    reg_req.wr    = 1'b1;
    reg_req.addr  = a;
    reg_req.wdata = d;
    @(negedge clk_in);
    reg_req.wr    = 1'b0;
  endtask

  // Register read: answer registered at the take edge, checked at the next falling edge
  task automatic reg_read(input logic [17:0] a, input logic [31:0] exp, input string msg);
    @(negedge clk_in);
    reg_req.rd   = 1'b1;
    reg_req.addr = a;
    @(negedge clk_in);
    reg_req.rd   = 1'b0;
    check(reg_ack_out === 1'b1 && reg_rdata_out === exp, msg);
  endtask

  // Command pulse: 0 arm, 1 stop, 2 force
  task automatic pulse(input int which);
    @(negedge clk_in);
    case (which)
      0: ctrl.arm = 1'b1;
      1: ctrl.stop = 1'b1;
      default: ctrl.force_trig = 1'b1;
    endcase
    @(negedge clk_in);
    ctrl.arm        = 1'b0;
    ctrl.stop       = 1'b0;
    ctrl.force_trig = 1'b0;
  endtask

  // Observe outputs for a fixed number of cycles
  task automatic watch(input int n);
    logic prev_clk;
    logic prev_trig;
    prev_clk   = conv_clk_out;
    prev_trig  = 1'b0;
    n_trig     = 0;
    n_pin      = 0;
    n_cap      = 0;
    n_clk      = 0;
    first_trig = -1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk_in);
      if (prev_trig === 1'b1 && n_trig == 1) begin
        ts_a = timestamp_out;
        tc_a = i;
      end
      if (prev_trig === 1'b1 && n_trig == 2) begin
        ts_b = timestamp_out;
        tc_b = i;
      end
      prev_trig = trig_out;
      if (trig_out === 1'b1) begin
        if (first_trig < 0) first_trig = i;
        n_trig++;
      end
      if (trig_pin_out === 1'b1) n_pin++;
      if (capture_en_out === 1'b1) n_cap++;
      if (conv_clk_out !== prev_clk) n_clk++;
      prev_clk = conv_clk_out;
    end
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    $display("Error at %0t: run limit reached", $time);
    report_and_stop();
  end

  //------------------------------------------------------------
  // Main sequence
  //------------------------------------------------------------
  initial begin
    sys_rst_in     = 1'b1;
    reg_req        = '0;
    ctrl           = '0;
    ctrl.os_factor = 16'h0001;
    src            = '0;
    chan_cond      = 64'h0000_0000_0000_0000;
    extra_fitted   = 1'b0;
    repeat (8) @(negedge clk_in);
    sys_rst_in = 1'b0;
    // Reset values, access kinds, unmapped place
    reg_read(`OFS_OR_SEL, 32'h0000_0001, "or select reset");
    reg_read(`OFS_CH_SEL_LO, 32'h0000_0000, "chan select low reset");
    reg_read(`OFS_CH_SEL_HI, 32'h0000_0000, "chan select high reset");
    reg_read(`OFS_OR_AVAIL, 32'h0000_0003, "or available");
    reg_read(`OFS_CH_AVAIL_LO, `CH_AVAIL_LO, "chan available low");
    reg_read(`OFS_CH_AVAIL_HI, 32'h0000_0000, "chan available high");
    reg_read(`OFS_OS_FACTOR, 32'h0000_0001, "os factor reset");
    reg_read(18'h09DDB, 32'h0000_0000, "unmapped read");
    reg_write(`OFS_OR_AVAIL, 32'hFFFF_FFFF);
    reg_read(`OFS_OR_AVAIL, 32'h0000_0003, "read-only write ignored");
    reg_write(`OFS_CH_SEL_LO, 32'hA5A5_0000);
    reg_write(`OFS_CH_SEL_HI, 32'h0000_5A5A);
    reg_read(`OFS_CH_SEL_LO, 32'hA5A5_0000, "chan select low");
    reg_read(`OFS_CH_SEL_HI, 32'h0000_5A5A, "chan select high");
    extra_fitted = 1'b1;
    watch(2);
    reg_read(`OFS_OR_AVAIL, 32'h0000_0303, "or available fitted");
    $display("Test registers done");
    // Software trigger free runs, oversampling and clock output
    reg_write(`OFS_CH_SEL_LO, 32'h0000_0000);
    reg_write(`OFS_CH_SEL_HI, 32'h0000_0000);
    ctrl.trig_en               = 1'b1;
    ctrl.trigger_out_direction = 1'b1;
    ctrl.clk_out_en            = 1'b1;
    ctrl.os_factor             = 16'h0004;
    pulse(0);
    watch(60);
    check(n_trig >= 2, "software trigger free run");
    check(n_pin == n_trig, "pin marks internal triggers");
    check(trig_pin_oe_out === 1'b1, "pin driven");
    check(n_cap == 15, "capture tick once per factor");
    check(n_clk == 60, "clock output toggles");
    check((ts_b - ts_a) === 48'(tc_b - tc_a), "timestamp at converter rate");
    reg_read(`OFS_OS_FACTOR, 32'h0000_0004, "os factor four");
    $display("Test software trigger done");
    // No source selected, then one force
    reg_write(`OFS_OR_SEL, 32'h0000_0000);
    watch(40);
    watch(40);
    check(n_trig == 0, "no source selected");
    check(waiting_out === 1'b1, "waiting for trigger");
    pulse(2);
    watch(60);
    check(n_trig == 1, "force gives one trigger");
    check(n_pin == 1, "force marked on pin");
    check(waiting_out === 1'b1, "waiting again after force");
    $display("Test force done");
    // Delay and pipeline compensation
    ctrl.os_factor = 16'h0001;
    pulse(2);
    watch(100);
    lat0 = first_trig;
    ctrl.delay = 16'h0005;
    pulse(2);
    watch(100);
    check(first_trig == lat0 + 5, "programmable delay");
    ctrl.delay     = 16'h0000;
    ctrl.os_factor = 16'h0002;
    pulse(2);
    watch(100);
    check(first_trig >= 0 && lat0 > first_trig + 5, "no compensation when oversampling");
    ctrl.os_factor = 16'h0000;
    reg_read(`OFS_OS_FACTOR, 32'h0000_0001, "factor zero reads one");
    ctrl.os_factor = 16'h0001;
    $display("Test delay done");
    // Global enable and external inputs
    reg_write(`OFS_OR_SEL, 32'h0000_0002);
    ctrl.trig_en   = 1'b0;
    src.ext_cond   = 2'b01;
    watch(40);
    check(n_trig == 0, "global enable blocks");
    ctrl.trig_en = 1'b1;
    watch(40);
    check(n_trig >= 1, "external input zero");
    check(n_pin == 0, "external not forwarded");
    src.ext_cond = 2'b10;
    reg_write(`OFS_OR_SEL, 32'h0000_0004);
    watch(40);
    watch(40);
    check(n_trig == 0, "absent external input one");
    src.ext_cond   = 2'b00;
    src.extra_cond = 2'b10;
    extra_fitted   = 1'b0;
    reg_write(`OFS_OR_SEL, 32'h0000_0200);
    watch(40);
    watch(40);
    check(n_trig == 0, "extra input absent");
    extra_fitted = 1'b1;
    watch(40);
    check(n_trig >= 1, "extra input one fitted");
    check(n_pin == 0, "extra input not forwarded");
    src.extra_cond = 2'b00;
    reg_write(`OFS_OR_SEL, 32'h0000_0000);
    watch(40);
    $display("Test sources done");
    // Channel masks and AND stage
    reg_write(`OFS_CH_SEL_LO, 32'h0000_0108);
    reg_write(`OFS_CH_SEL_HI, 32'h0000_0001);
    chan_cond = 64'h0000_0001_0000_0100;
    watch(40);
    check(n_trig == 0, "absent channels ignored");
    chan_cond = 64'h0000_0000_0000_0008;
    watch(40);
    check(n_trig >= 1, "channel three selected");
    check(n_pin >= 1, "channel cause on pin");
    chan_cond   = 64'h0000_0000_0000_0000;
    src.and_hit = 1'b1;
    watch(40);
    check(n_trig >= 1, "and stage result");
    src.and_hit = 1'b0;
    watch(40);
    $display("Test channels done");
    // Stop, force outside waiting, pin and clock off
    pulse(1);
    watch(20);
    check(waiting_out === 1'b0, "stopped");
    pulse(2);
    watch(40);
    check(n_trig == 0, "force outside waiting ignored");
    ctrl.trigger_out_direction = 1'b0;
    ctrl.clk_out_en            = 1'b0;
    watch(4);
    watch(10);
    check(trig_pin_oe_out === 1'b0, "pin released");
    check(n_clk == 0 && conv_clk_out === 1'b0, "clock output off");
    $display("Test stop done");
    report_and_stop();
  end
endmodule // trigger_or_mask_engine_test
`default_nettype wire
